/* common/rtsc_pkg.sv */
// Package with constants for the reset and test-strap control block
package rtsc_pkg;

  // Clock rate and strap sampling delay
  localparam int unsigned CLK_PERIOD_PS   = 50000;   // 20 MHz clock period
  localparam int unsigned STRAP_DELAY_PS  = 1500000; // About 1.5 us after release
  // Longest time rounds down, at least one cycle
  localparam int unsigned STRAP_DELAY_CYC = (STRAP_DELAY_PS / CLK_PERIOD_PS) < 1 ? 1
                                          : (STRAP_DELAY_PS / CLK_PERIOD_PS);

  // Host-side quiet time before the first control bus access
  localparam int unsigned BUS_QUIET_MS    = 500;     // 500 ms after both high
  localparam int unsigned BUS_QUIET_CYC   = BUS_QUIET_MS * 20000;

  // Widths
  localparam int unsigned GP_PINS         = 20;      // Pins 19:00
  localparam int unsigned DLY_W           = 8;       // Strap delay counter width
  localparam int unsigned QUIET_W         = 24;      // Quiet counter width
  localparam int unsigned TMS_W           = 3;       // Test-mode select width
  localparam int unsigned TMS_STRAP_BIT   = 0;       // Strap feeds this bit

  // Reset values
  localparam logic [DLY_W-1:0]   DLY_RST   = 8'h00;
  localparam logic [QUIET_W-1:0] QUIET_RST = 24'h000000;
  localparam logic [TMS_W-1:0]   TMS_RST   = 3'h0;

  // Sequencer states
  typedef enum logic [1:0] {
    RTSC_HOLD   = 2'b00,  // Reset held, outputs parked
    RTSC_STRAP  = 2'b01,  // Waiting to sample the strap
    RTSC_CONFIG = 2'b10,  // Self-configuration, bus quiet time
    RTSC_RUN    = 2'b11   // Normal operation
  } rtsc_state_t;

endpackage : rtsc_pkg

/* rtl/rtsc_rst_sync.sv */
// Reset synchroniser: asynchronous assert, clocked release
`timescale 1ns/1ps
module rtsc_rst_sync (
  // Clock and raw reset
  input  wire logic clk,
  input  wire logic arst,
  // Synchronised reset
  output logic      srst
);
  logic meta_q;  // First stage, read only by the second
  logic sync_q;  // Second stage

  // Two-stage release synchroniser
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= 1'b0;
      sync_q <= meta_q;
    end
  end

  assign srst = sync_q;
endmodule : rtsc_rst_sync

/* rtl/rtsc_top.sv */
// Reset and test-strap sequencer for the display controller
`timescale 1ns/1ps
module rtsc_top
  import rtsc_pkg::*;
#(
  parameter int unsigned QUIET_CYCLES = BUS_QUIET_CYC  // Shorten in simulation
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST,
  // Host control inputs
  input  wire logic                 POWER_ON_RESET_N,
  input  wire logic                 FAST_MIRROR_PARK_N,
  // Test point zero, three-signal pin
  input  wire logic                 TEST_POINT_ZERO_I,
  output logic                      TEST_POINT_ZERO_O,
  output logic                      TEST_POINT_ZERO_OE_N,
  // Functional values from the core
  input  wire logic                 CORE_FLASH_CLOCK,
  input  wire logic                 CORE_FLASH_DATA_OUT,
  input  wire logic                 CORE_FLASH_SELECT_0_N,
  input  wire logic                 CORE_FLASH_SELECT_1_N,
  input  wire logic [GP_PINS-1:0]   CORE_GP_OUT,
  input  wire logic [GP_PINS-1:0]   CORE_GP_DIR_OUT,
  input  wire logic                 CORE_LIGHT_SELECT_0,
  input  wire logic                 CORE_LIGHT_SELECT_1,
  input  wire logic                 CORE_MIRROR_ENABLE,
  input  wire logic                 CORE_TEST_OUT,
  // Flash port pins
  output logic                      FLASH_PORT_CLOCK,
  output logic                      FLASH_PORT_CLOCK_OE_N,
  output logic                      FLASH_PORT_DATA_OUT,
  output logic                      FLASH_PORT_DATA_OUT_OE_N,
  output logic                      FLASH_PORT_SELECT_0_N,
  output logic                      FLASH_PORT_SELECT_0_N_OE_N,
  output logic                      FLASH_PORT_SELECT_1_N,
  output logic                      FLASH_PORT_SELECT_1_N_OE_N,
  // General purpose pins
  output logic [GP_PINS-1:0]        GP_OUT,
  output logic [GP_PINS-1:0]        GP_OE_N,
  // Forced-low outputs
  output logic                      LIGHT_SOURCE_SELECT_0,
  output logic                      LIGHT_SOURCE_SELECT_1,
  output logic                      MIRROR_ARRAY_ENABLE_RESET_N,
  // Status to the core
  output logic [TMS_W-1:0]          TEST_MODE_SELECT,
  output logic                      CONFIG_START,
  output logic                      CORE_ACTIVE,
  output logic                      BUS_READY
);

  // Combined reset: board reset or the device power-on reset pin
  wire logic arst = RST | ~POWER_ON_RESET_N;
  logic      srst;  // Synchronised reset, released cleanly

  // Release synchroniser; asserting stays asynchronous
  // Two flops, so that a release close to an edge cannot split the state registers
  rtsc_rst_sync u_sync (
    .clk  (CLK),
    .arst (arst),
    .srst (srst)
  );

  // Counters and flags of the sequencer, all cleared by the synchronised reset
  rtsc_state_t        state_q, state_d;   // Sequencer state
  logic [DLY_W-1:0]   dly_q, dly_d;       // Strap delay counter
  logic [QUIET_W-1:0] quiet_q, quiet_d;   // Bus quiet counter
  logic [TMS_W-1:0]   tms_q, tms_d;       // Test-mode select
  logic               start_q, start_d;   // Self-config start pulse
  logic               drive_q;            // Pins leave high impedance
  logic               strap_done_q;       // Test point becomes an output

  // Decode of sequencer conditions
  wire logic in_hold    = (state_q == RTSC_HOLD);
  wire logic dly_end    = (dly_q == DLY_W'(STRAP_DELAY_CYC - 1));
  wire logic quiet_end  = (quiet_q == QUIET_W'(QUIET_CYCLES - 1));
  wire logic park_ok    = FAST_MIRROR_PARK_N;
  // One term drives both the strap sample and the pin hand-over,
  // so the test point can never turn into an output before it was read
  wire logic strap_take = (state_q == RTSC_STRAP) & dly_end;

  // Next-state logic of the sequencer
  always_comb begin
    state_d = state_q;
    dly_d   = dly_q;
    quiet_d = quiet_q;
    tms_d   = tms_q;
    start_d = 1'b0;
    unique case (state_q)
      RTSC_HOLD: begin
        // First clean cycle after release is the rising edge
        state_d = RTSC_STRAP;
        start_d = 1'b1;
        dly_d   = DLY_RST;
      end
      RTSC_STRAP: begin
        // Counter runs from zero, so the last count is one below the delay
        dly_d = dly_q + DLY_W'(1);
        if (dly_end) begin
          // Only bit zero comes from this strap
          tms_d[TMS_STRAP_BIT] = TEST_POINT_ZERO_I;
          state_d              = RTSC_CONFIG;
          quiet_d              = QUIET_RST;
        end
      end
      RTSC_CONFIG: begin
        // Quiet time counts only while park is released
        // A park pulse restarts the count rather than pausing it, so the host
        // always gets a full quiet time after the last park request
        if (!park_ok) begin
          quiet_d = QUIET_RST;
        end else if (quiet_end) begin
          state_d = RTSC_RUN;
        end else begin
          quiet_d = quiet_q + QUIET_W'(1);
        end
      end
      RTSC_RUN: begin
        // Only a reset leaves normal operation
        state_d = RTSC_RUN;
      end
    endcase
  end

  // Sequencer registers; constants only under reset
  always_ff @(posedge CLK or posedge srst) begin
    if (srst) begin
      state_q <= RTSC_HOLD;
      dly_q   <= DLY_RST;
      quiet_q <= QUIET_RST;
      tms_q   <= TMS_RST;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      dly_q   <= dly_d;
      quiet_q <= quiet_d;
      tms_q   <= tms_d;
      start_q <= start_d;
    end
  end

  // Pin drive enables; cleared the instant reset asserts
  // Pins wake one cycle after the state leaves hold, as the output flops add a stage
  always_ff @(posedge CLK or posedge srst) begin
    if (srst) begin
      drive_q      <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      drive_q      <= 1'b1;
      // Once set, the test point stays an output until the next reset
      strap_done_q <= strap_done_q | strap_take;
    end
  end

  // Every output is registered; the raw reset clears them at once
  // The raw reset is used here rather than the synchronised one, so the pins float
  // even before any clock runs; the cost is a reset load on every pin flop
  always_ff @(posedge CLK or posedge arst) begin
    if (arst) begin
      // Flash port floats; selects rest at their inactive level
      FLASH_PORT_CLOCK            <= 1'b0;
      FLASH_PORT_CLOCK_OE_N       <= 1'b1;
      FLASH_PORT_DATA_OUT         <= 1'b0;
      FLASH_PORT_DATA_OUT_OE_N    <= 1'b1;
      FLASH_PORT_SELECT_0_N       <= 1'b1;
      FLASH_PORT_SELECT_0_N_OE_N  <= 1'b1;
      FLASH_PORT_SELECT_1_N       <= 1'b1;
      FLASH_PORT_SELECT_1_N_OE_N  <= 1'b1;
      // General pins float; board pulls set their level
      GP_OUT                      <= {GP_PINS{1'b0}};
      GP_OE_N                     <= {GP_PINS{1'b1}};
      // Light selects and mirror enable are driven low, not floated
      LIGHT_SOURCE_SELECT_0       <= 1'b0;
      LIGHT_SOURCE_SELECT_1       <= 1'b0;
      MIRROR_ARRAY_ENABLE_RESET_N <= 1'b0;
      // Test point floats so the strap level can settle
      TEST_POINT_ZERO_O           <= 1'b0;
      TEST_POINT_ZERO_OE_N        <= 1'b1;
      // Status back to idle
      TEST_MODE_SELECT            <= TMS_RST;
      CONFIG_START                <= 1'b0;
      CORE_ACTIVE                 <= 1'b0;
      BUS_READY                   <= 1'b0;
    end else begin
      // Flash port follows the core once the release has gone through
      FLASH_PORT_CLOCK            <= drive_q & CORE_FLASH_CLOCK;
      FLASH_PORT_CLOCK_OE_N       <= ~drive_q;
      FLASH_PORT_DATA_OUT         <= drive_q & CORE_FLASH_DATA_OUT;
      FLASH_PORT_DATA_OUT_OE_N    <= ~drive_q;
      FLASH_PORT_SELECT_0_N       <= ~drive_q | CORE_FLASH_SELECT_0_N;
      FLASH_PORT_SELECT_0_N_OE_N  <= ~drive_q;
      FLASH_PORT_SELECT_1_N       <= ~drive_q | CORE_FLASH_SELECT_1_N;
      FLASH_PORT_SELECT_1_N_OE_N  <= ~drive_q;
      // Core may turn unused general pins into outputs
      GP_OUT                      <= {GP_PINS{drive_q}} & CORE_GP_OUT;
      GP_OE_N                     <= ~({GP_PINS{drive_q}} & CORE_GP_DIR_OUT);
      // Forced-low outputs follow the core only after release
      LIGHT_SOURCE_SELECT_0       <= drive_q & CORE_LIGHT_SELECT_0;
      LIGHT_SOURCE_SELECT_1       <= drive_q & CORE_LIGHT_SELECT_1;
      MIRROR_ARRAY_ENABLE_RESET_N <= drive_q & CORE_MIRROR_ENABLE;
      // Driven only once the strap has been taken
      TEST_POINT_ZERO_O           <= strap_done_q & CORE_TEST_OUT;
      TEST_POINT_ZERO_OE_N        <= ~strap_done_q;
      // Status to the core
      TEST_MODE_SELECT            <= tms_q;
      CONFIG_START                <= start_q;
      CORE_ACTIVE                 <= ~in_hold;
      BUS_READY                   <= (state_q == RTSC_RUN);
    end
  end

endmodule : rtsc_top

/* tb/rtsc_host_model.sv */
// Host and power-management model: reset, park and the strap pull
`timescale 1ns/1ps
module rtsc_host_model (
  // Clock and pin from the device
  input  wire logic clk,
  input  wire logic tp_o,
  input  wire logic tp_oe_n,
  // Host drives
  output logic      por_n,
  output logic      park_n,
  output logic      tp_i
);
  logic strap_up;  // External pullup fitted
  initial begin
    por_n = 1'b0;
    park_n = 1'b0;
    strap_up = 1'b0;
  end
  // Released pin settles to its pull level, never the last driven value
  assign tp_i = tp_oe_n ? strap_up : tp_o;
  // Reset, park high, then release once supplies are steady
  task automatic power_up(input logic up);
    @(negedge clk) por_n = 1'b0;
    strap_up = up;
    repeat (2) @(negedge clk);
    park_n = 1'b1;
    @(negedge clk) por_n = 1'b1;
  endtask : power_up
  // Short park request
  task automatic park_blip(input int n);
    @(negedge clk) park_n = 1'b0;
    repeat (n) @(negedge clk);
    park_n = 1'b1;
  endtask : park_blip
endmodule : rtsc_host_model

/* tb/rtsc_top_sva.sv */
// Checker for the reset and test-strap sequencer
`timescale 1ns/1ps
module rtsc_top_sva
  import rtsc_pkg::*;
#(
  parameter int unsigned QUIET_CYCLES = BUS_QUIET_CYC  // Quiet time, from the top
) (
  // Clock, resets and host inputs
  input wire logic               CLK,
  input wire logic               RST,
  input wire logic               POWER_ON_RESET_N,
  input wire logic               FAST_MIRROR_PARK_N,
  // Test point and pin enables
  input wire logic               TEST_POINT_ZERO_I,
  input wire logic               TEST_POINT_ZERO_OE_N,
  input wire logic               FLASH_PORT_CLOCK_OE_N,
  input wire logic               FLASH_PORT_DATA_OUT_OE_N,
  input wire logic               FLASH_PORT_SELECT_0_N_OE_N,
  input wire logic               FLASH_PORT_SELECT_1_N_OE_N,
  input wire logic [GP_PINS-1:0] GP_OE_N,
  // Forced-low outputs and status
  input wire logic               LIGHT_SOURCE_SELECT_0,
  input wire logic               LIGHT_SOURCE_SELECT_1,
  input wire logic               MIRROR_ARRAY_ENABLE_RESET_N,
  input wire logic [TMS_W-1:0]   TEST_MODE_SELECT,
  input wire logic               CONFIG_START,
  input wire logic               CORE_ACTIVE,
  input wire logic               BUS_READY
);
  logic        in_rst;  // Either reset source
  logic [5:0]  rel_q;   // Cycles since release, saturating
  logic [31:0] park_q;  // Cycles with park high
  assign in_rst = RST | ~POWER_ON_RESET_N;
  // Release counter: bounds the strap delay
  always_ff @(posedge CLK or posedge in_rst) begin
    if (in_rst) rel_q <= 6'h00;
    else if (rel_q != 6'h3F) rel_q <= rel_q + 6'h01;
  end
  // Park-high counter: ready must never beat the quiet time
  always_ff @(posedge CLK or posedge in_rst) begin
    if (in_rst) park_q <= 32'h0;
    else if (!FAST_MIRROR_PARK_N) park_q <= 32'h0;
    else park_q <= park_q + 32'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  property p_float; in_rst |-> &{FLASH_PORT_CLOCK_OE_N, FLASH_PORT_DATA_OUT_OE_N, FLASH_PORT_SELECT_0_N_OE_N,
    FLASH_PORT_SELECT_1_N_OE_N, GP_OE_N, TEST_POINT_ZERO_OE_N}; endproperty
  a_float: assert property (p_float) else $error("pin driven in reset");
  property p_low; in_rst |-> !(LIGHT_SOURCE_SELECT_0 | LIGHT_SOURCE_SELECT_1 | MIRROR_ARRAY_ENABLE_RESET_N); endproperty
  a_low: assert property (p_low) else $error("forced output high in reset");
  property p_idle; in_rst |-> !(CONFIG_START | CORE_ACTIVE | BUS_READY) && TEST_MODE_SELECT == 3'h0; endproperty
  a_idle: assert property (p_idle) else $error("status active in reset");
  property p_start; disable iff (in_rst) $fell(in_rst) |-> ##[2:5] CONFIG_START; endproperty
  a_start: assert property (p_start) else $error("no start after release");
  property p_pulse; disable iff (in_rst) CONFIG_START |=> !CONFIG_START; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_sval; disable iff (in_rst)
    $fell(TEST_POINT_ZERO_OE_N) |-> TEST_MODE_SELECT == {2'b00, $past(TEST_POINT_ZERO_I, 2)}; endproperty
  a_sval: assert property (p_sval) else $error("wrong strap value");
  property p_stime; disable iff (in_rst) $fell(TEST_POINT_ZERO_OE_N) |-> rel_q inside {[30:38]}; endproperty
  a_stime: assert property (p_stime) else $error("strap taken at wrong time");
  property p_ready; disable iff (in_rst) $rose(BUS_READY) |-> park_q >= QUIET_CYCLES; endproperty
  a_ready: assert property (p_ready) else $error("bus ready too early");
  c_start: cover property (disable iff (in_rst) CONFIG_START);
  c_strap: cover property (disable iff (in_rst) $fell(TEST_POINT_ZERO_OE_N) && TEST_MODE_SELECT[0]);
  c_ready: cover property (disable iff (in_rst) $rose(BUS_READY));
endmodule : rtsc_top_sva
bind rtsc_top rtsc_top_sva #(.QUIET_CYCLES(QUIET_CYCLES)) u_sva (.*);

/* tb/rtsc_top_test.sv */
// Self-checking bench for the reset and test-strap sequencer
`timescale 1ns/1ps
module rtsc_top_test;
  import rtsc_pkg::*;
  localparam int unsigned QUIET = 20;  // Short quiet time
  logic               clk, rst, por_n, park_n, tp_i, tp_o, tp_oe_n, cv;
  logic               ls0, ls1, mir, cfg, act, rdy;
  logic [3:0]         fl_oe_n, fl_v;  // Flash enables and values: clock, data, select 0, select 1
  logic [GP_PINS-1:0] gp_dir, gp_oe_n, gp_v;
  logic [TMS_W-1:0]   tms;
  int                 failures, n_checks;
  rtsc_host_model host (.clk(clk), .tp_o(tp_o), .tp_oe_n(tp_oe_n), .por_n(por_n), .park_n(park_n), .tp_i(tp_i));
  rtsc_top #(.QUIET_CYCLES(QUIET)) dut (.CLK(clk), .RST(rst), .POWER_ON_RESET_N(por_n),
    .FAST_MIRROR_PARK_N(park_n), .TEST_POINT_ZERO_I(tp_i), .TEST_POINT_ZERO_O(tp_o),
    .TEST_POINT_ZERO_OE_N(tp_oe_n), .CORE_FLASH_CLOCK(cv), .CORE_FLASH_DATA_OUT(cv),
    .CORE_FLASH_SELECT_0_N(cv), .CORE_FLASH_SELECT_1_N(cv), .CORE_GP_OUT({GP_PINS{cv}}),
    .CORE_GP_DIR_OUT(gp_dir), .CORE_LIGHT_SELECT_0(cv), .CORE_LIGHT_SELECT_1(cv),
    .CORE_MIRROR_ENABLE(cv), .CORE_TEST_OUT(cv),
    .FLASH_PORT_CLOCK(fl_v[0]), .FLASH_PORT_CLOCK_OE_N(fl_oe_n[0]),
    .FLASH_PORT_DATA_OUT(fl_v[1]), .FLASH_PORT_DATA_OUT_OE_N(fl_oe_n[1]),
    .FLASH_PORT_SELECT_0_N(fl_v[2]), .FLASH_PORT_SELECT_0_N_OE_N(fl_oe_n[2]),
    .FLASH_PORT_SELECT_1_N(fl_v[3]), .FLASH_PORT_SELECT_1_N_OE_N(fl_oe_n[3]),
    .GP_OUT(gp_v), .GP_OE_N(gp_oe_n), .LIGHT_SOURCE_SELECT_0(ls0), .LIGHT_SOURCE_SELECT_1(ls1),
    .MIRROR_ARRAY_ENABLE_RESET_N(mir), .TEST_MODE_SELECT(tms), .CONFIG_START(cfg), .CORE_ACTIVE(act),
    .BUS_READY(rdy));
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Counts falling edges until the start pulse or, with on_rdy, bus ready is high
  task automatic wait_hi(input bit on_rdy, input int lim, output int n);
    n = 0;
    while ((on_rdy ? rdy : cfg) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_hi
  // Core drives every value high while reset is low
  task automatic t_hold;
    check({fl_oe_n, gp_oe_n, tp_oe_n}, 32'h01FFFFFF);
    check({ls0, ls1, mir}, 32'h0);
    check({cfg, act, rdy, tms}, 32'h0);
    check({fl_v, gp_v, tp_o}, {4'hC, 20'h00000, 1'b0});
    $display("test hold done");
  endtask : t_hold
  // Release with a given strap, then wait out the quiet time
  task automatic t_boot(input logic up);
    int n;
    host.power_up(up);
    wait_hi(1'b0, 50, n);
    check(n, 4);
    check({fl_v, fl_oe_n}, {{4{cv}}, 4'h0});
    check({gp_v, ls0, ls1, mir, act}, {{GP_PINS{cv}}, {3{cv}}, 1'b1});
    @(negedge clk);
    n++;
    check(cfg, 1'b0);
    while (tp_oe_n !== 1'b0 && n < 80) begin
      @(negedge clk);
      n++;
    end
    check(n >= 33 && n <= 38, 1);
    check(tms, {2'b00, up});
    check({gp_oe_n, tp_o}, {~gp_dir, cv});
    wait_hi(1'b1, 100, n); // Host stays off the bus until here
    check(n >= QUIET - 4 && n <= QUIET + 2, 1);
    $display("test boot done");
  endtask : t_boot
  // Park request in mid quiet time restarts the count
  task automatic t_park;
    int n;
    host.power_up(1'b0);
    repeat (45) @(negedge clk);
    host.park_blip(3);
    wait_hi(1'b1, 100, n);
    check(n >= QUIET - 2 && n <= QUIET + 2, 1);
    // Core now drives every value low; pins must follow it
    cv = 1'b0;
    @(negedge clk);
    check({fl_v, gp_v, ls0, ls1, mir, tp_o}, 32'h0);
    $display("test park done");
  endtask : t_park
  // Verdict
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    rst = 1'b1;
    cv = 1'b1;
    gp_dir = 20'hA5A5C;
    failures = 0;
    n_checks = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_hold;
    t_boot(1'b0);
    t_boot(1'b1);
    t_park;
    conclude;
  end
  // Watchdog
  initial begin
    #(3000 * 50);
    failures++;
    conclude;
  end
endmodule : rtsc_top_test
